// ===== core/cfg_row_pkg.sv
// Package: field layout, factory values and addresses of the power-on configuration row
package cfg_row_pkg;

  // ****************************************
  // Addresses
  // ****************************************
  localparam logic [31:0] ROW_BASE_ADDR = 32'h0080_4000;
  localparam logic [31:0] ROW_LO_ADDR   = 32'h0080_4000;
  localparam logic [31:0] ROW_HI_ADDR   = 32'h0080_4004;
  localparam logic [31:0] PROG_LO_ADDR  = 32'h0000_0000;
  localparam logic [31:0] PROG_HI_ADDR  = 32'h0000_0004;
  localparam logic [31:0] STATUS_ADDR   = 32'h0000_0008;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BOOT_LSB   = 0;
  localparam int EEP_LSB    = 4;
  localparam int BOD_LVL_LSB = 8;
  localparam int BOD_DIS_BIT = 14;
  localparam int BOD_ACT_LSB = 15;
  localparam int WDT_EN_BIT  = 26;
  localparam int WDT_AON_BIT = 27;
  localparam int WDT_PER_LSB = 28;
  localparam int WDT_WIN_LSB = 32;
  localparam int WDT_EWO_LSB = 36;
  localparam int WDT_WEN_BIT = 40;
  localparam int BOD_HYS_BIT = 41;
  localparam int LOCK_LSB    = 48;

  // ****************************************
  // Factory row value
  // ****************************************
  localparam logic [63:0] ROW_FACTORY = 64'hffff_f8bb_b11e_86ff;

  // Fetch takes two word reads of the array
  localparam logic [1:0] FETCH_WORDS = 2'h2;

  typedef struct packed {
    logic [2:0]  boot_region_size;
    logic [2:0]  eeprom_region_size;
    logic [15:0] region_lock;
  } nvm_cfg_t;

  typedef struct packed {
    logic [5:0] level;
    logic       disable_bit;
    logic [1:0] action;
    logic       hysteresis;
  } brownout_cfg_t;

  typedef struct packed {
    logic       enable;
    logic       always_on;
    logic [3:0] period;
    logic [3:0] window;
    logic [3:0] early_warning_offset;
    logic       window_enable;
  } watchdog_cfg_t;

endpackage

// ===== core/power_on_config_row_loader.sv
// Power-on loader of the 64-bit configuration row
//
// Chosen here: the plain strobed port.
`timescale 1ns/100ps
module power_on_config_row_loader (
  input  wire logic                        clk,
  input  wire logic                        reset,
  input  wire logic [31:0]                 addr,
  input  wire logic [31:0]                 wdata,
  input  wire logic                        wr,
  input  wire logic                        rd,
  output logic      [31:0]                 rdata,
  output cfg_row_pkg::nvm_cfg_t            nvm_cfg,
  output cfg_row_pkg::brownout_cfg_t       brownout_cfg,
  output cfg_row_pkg::watchdog_cfg_t       watchdog_cfg,
  output logic                             periph_reset
);

  // ****************************************
  // Nonvolatile row array
  // ****************************************
  // Two stored words; survive device reset, so no reset term
  logic [31:0] array_r [2];
  logic        init_r = 1'b0;
  logic        init_nxt;
  logic [31:0] wlo_nxt;
  logic [31:0] whi_nxt;

  always_comb begin
    init_nxt = 1'b1;
    wlo_nxt  = array_r[0];
    whi_nxt  = array_r[1];
    if (!init_r) begin
      wlo_nxt = cfg_row_pkg::ROW_FACTORY[31:0];
      whi_nxt = cfg_row_pkg::ROW_FACTORY[63:32];
    end else if (wr && addr == cfg_row_pkg::PROG_LO_ADDR) begin
      wlo_nxt = wdata;
    end else if (wr && addr == cfg_row_pkg::PROG_HI_ADDR) begin
      whi_nxt = wdata;
    end
  end

  // Array gets the factory row at first power-on, then changes only on program writes
  always_ff @(posedge clk) begin
    init_r     <= init_nxt;
    array_r[0] <= wlo_nxt;
    array_r[1] <= whi_nxt;
  end

  // ****************************************
  // Fetch sequencer
  // ****************************************
  typedef enum logic [1:0] {
    ST_FETCH = 2'b00,
    ST_APPLY = 2'b01,
    ST_DONE  = 2'b10
  } state_t;

  state_t      state_r;
  state_t      state_nxt;
  logic [1:0]  idx_r;
  logic [1:0]  idx_nxt;
  logic [63:0] row_r;
  logic [63:0] row_nxt;

  always_comb begin
    state_nxt = state_r;
    idx_nxt   = idx_r;
    row_nxt   = row_r;
    unique case (state_r)
      ST_FETCH: begin
        if (idx_r == 2'h0) begin
          row_nxt[31:0] = array_r[0];
        end else begin
          row_nxt[63:32] = array_r[1];
        end
        idx_nxt = idx_r + 2'h1;
        if (idx_r + 2'h1 == cfg_row_pkg::FETCH_WORDS) begin
          state_nxt = ST_APPLY;
        end
      end
      ST_APPLY: state_nxt = ST_DONE;
      ST_DONE:  state_nxt = ST_DONE;
      default:  state_nxt = ST_FETCH;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= ST_FETCH;
      idx_r   <= 2'h0;
      row_r   <= cfg_row_pkg::ROW_FACTORY;
    end else begin
      state_r <= state_nxt;
      idx_r   <= idx_nxt;
      row_r   <= row_nxt;
    end
  end

  // ****************************************
  // Field distribution
  // ****************************************
  cfg_row_pkg::nvm_cfg_t      nvm_nxt;
  cfg_row_pkg::brownout_cfg_t bod_nxt;
  cfg_row_pkg::watchdog_cfg_t wdt_nxt;
  logic                       prst_nxt;

  always_comb begin
    nvm_nxt  = nvm_cfg;
    bod_nxt  = brownout_cfg;
    wdt_nxt  = watchdog_cfg;
    prst_nxt = (state_r != ST_DONE) && (state_nxt != ST_DONE);
    // Latched only at the end of a fetch
    if (state_r == ST_APPLY) begin
      nvm_nxt.boot_region_size     = row_r[cfg_row_pkg::BOOT_LSB +: 3];
      nvm_nxt.eeprom_region_size   = row_r[cfg_row_pkg::EEP_LSB +: 3];
      bod_nxt.level                = row_r[cfg_row_pkg::BOD_LVL_LSB +: 6];
      bod_nxt.disable_bit          = row_r[cfg_row_pkg::BOD_DIS_BIT];
      bod_nxt.action               = row_r[cfg_row_pkg::BOD_ACT_LSB +: 2];
      bod_nxt.hysteresis           = row_r[cfg_row_pkg::BOD_HYS_BIT];
      wdt_nxt.enable               = row_r[cfg_row_pkg::WDT_EN_BIT];
      wdt_nxt.always_on            = row_r[cfg_row_pkg::WDT_AON_BIT];
      wdt_nxt.period               = row_r[cfg_row_pkg::WDT_PER_LSB +: 4];
      wdt_nxt.window               = row_r[cfg_row_pkg::WDT_WIN_LSB +: 4];
      wdt_nxt.early_warning_offset = row_r[cfg_row_pkg::WDT_EWO_LSB +: 4];
      wdt_nxt.window_enable        = row_r[cfg_row_pkg::WDT_WEN_BIT];
      nvm_nxt.region_lock          = row_r[cfg_row_pkg::LOCK_LSB +: 16];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      nvm_cfg      <= '{3'h7, 3'h7, 16'hffff};
      brownout_cfg <= '{6'h06, 1'b0, 2'h1, 1'b0};
      watchdog_cfg <= '{1'b0, 1'b0, 4'hb, 4'hb, 4'hb, 1'b0};
      periph_reset <= 1'b1;
    end else begin
      nvm_cfg      <= nvm_nxt;
      brownout_cfg <= bod_nxt;
      watchdog_cfg <= wdt_nxt;
      periph_reset <= prst_nxt;
    end
  end

  // ****************************************
  // Register read port
  // ****************************************
  logic [31:0] rdata_nxt;

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (rd) begin
      unique case (addr)
        cfg_row_pkg::ROW_LO_ADDR:  rdata_nxt = array_r[0];
        cfg_row_pkg::ROW_HI_ADDR:  rdata_nxt = array_r[1];
        cfg_row_pkg::PROG_LO_ADDR: rdata_nxt = array_r[0];
        cfg_row_pkg::PROG_HI_ADDR: rdata_nxt = array_r[1];
        cfg_row_pkg::STATUS_ADDR:  rdata_nxt = {30'h0, state_r};
        default:                   rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= rdata_nxt;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence fetch_seq;
    state_r == ST_FETCH ##1 state_r == ST_FETCH ##1 state_r == ST_APPLY;
  endsequence

  AST_FETCH_AFTER_RESET: assert property (@(posedge clk)
    $fell(reset) |-> fetch_seq ##1 state_r == ST_DONE)
    else $error("fetch sequence wrong after reset");

  AST_RELEASE_LATE: assert property (@(posedge clk) disable iff (reset)
    $fell(periph_reset) |-> $past(state_r) == ST_APPLY)
    else $error("peripherals released before apply");

  AST_HELD_DURING_FETCH: assert property (@(posedge clk) disable iff (reset)
    state_r != ST_DONE |-> periph_reset)
    else $error("peripherals released during fetch");

  AST_STABLE_AFTER: assert property (@(posedge clk) disable iff (reset)
    state_r == ST_DONE && $past(state_r) == ST_DONE |-> $stable(watchdog_cfg)
      && $stable(brownout_cfg) && $stable(nvm_cfg))
    else $error("settings changed without reset");

  AST_BOOT_FIELD: assert property (@(posedge clk) disable iff (reset)
    state_r == ST_DONE && $past(state_r) == ST_APPLY |->
      nvm_cfg.boot_region_size == $past(row_r[2:0]))
    else $error("boot region size not loaded");

  AST_LOCK_FIELD: assert property (@(posedge clk) disable iff (reset)
    state_r == ST_DONE && $past(state_r) == ST_APPLY |->
      nvm_cfg.region_lock == $past(row_r[63:48]))
    else $error("region lock not loaded");

  AST_BOD_FIELD: assert property (@(posedge clk) disable iff (reset)
    state_r == ST_DONE && $past(state_r) == ST_APPLY |->
      brownout_cfg.level == $past(row_r[13:8]) && brownout_cfg.hysteresis == $past(row_r[41]))
    else $error("brown-out fields not loaded");

  AST_WDT_FIELD: assert property (@(posedge clk) disable iff (reset)
    state_r == ST_DONE && $past(state_r) == ST_APPLY |->
      watchdog_cfg.period == $past(row_r[31:28]) && watchdog_cfg.enable == $past(row_r[26]))
    else $error("watchdog fields not loaded");

  AST_ROW_READ: assert property (@(posedge clk) disable iff (reset)
    rd && addr == cfg_row_pkg::ROW_HI_ADDR |=> rdata == $past(array_r[1]))
    else $error("row high word read wrong");

  // Fields appear the cycle after apply
  sequence applied_seq;
    state_r == ST_APPLY ##1 state_r == ST_DONE;
  endsequence

  AST_EEP_FIELD: assert property (@(posedge clk) disable iff (reset)
    applied_seq |-> nvm_cfg.eeprom_region_size == $past(row_r[6:4]))
    else $error("eeprom region size not loaded");

  AST_BOD_DIS_FIELD: assert property (@(posedge clk) disable iff (reset)
    applied_seq |-> brownout_cfg.disable_bit == $past(row_r[14]))
    else $error("brown-out disable not loaded");

  AST_BOD_ACT_FIELD: assert property (@(posedge clk) disable iff (reset)
    applied_seq |-> brownout_cfg.action == $past(row_r[16:15]))
    else $error("brown-out action not loaded");

  AST_BOD_HYS_FIELD: assert property (@(posedge clk) disable iff (reset)
    applied_seq |-> brownout_cfg.hysteresis == $past(row_r[41]))
    else $error("brown-out hysteresis not loaded");

  AST_WDT_EN_FIELD: assert property (@(posedge clk) disable iff (reset)
    applied_seq |-> watchdog_cfg.enable == $past(row_r[26]))
    else $error("watchdog enable not loaded");

  AST_WDT_AON_FIELD: assert property (@(posedge clk) disable iff (reset)
    applied_seq |-> watchdog_cfg.always_on == $past(row_r[27]))
    else $error("watchdog always-on not loaded");

  AST_WDT_WIN_FIELD: assert property (@(posedge clk) disable iff (reset)
    applied_seq |-> watchdog_cfg.window == $past(row_r[35:32]))
    else $error("watchdog window time-out not loaded");

  AST_WDT_EWO_FIELD: assert property (@(posedge clk) disable iff (reset)
    applied_seq |-> watchdog_cfg.early_warning_offset == $past(row_r[39:36]))
    else $error("early warning offset not loaded");

  AST_WDT_WEN_FIELD: assert property (@(posedge clk) disable iff (reset)
    applied_seq |-> watchdog_cfg.window_enable == $past(row_r[40]))
    else $error("watchdog window enable not loaded");

  AST_RESET_HOLD: assert property (@(posedge clk)
    reset |=> periph_reset && rdata == 32'h0000_0000)
    else $error("peripherals not held in reset");

  AST_FACTORY_DEFAULTS: assert property (@(posedge clk)
    reset |=> nvm_cfg.boot_region_size == cfg_row_pkg::ROW_FACTORY[2:0]
      && watchdog_cfg.period == cfg_row_pkg::ROW_FACTORY[31:28])
    else $error("reset defaults differ from factory row");

  AST_ROW_LO_READ: assert property (@(posedge clk) disable iff (reset)
    rd && addr == cfg_row_pkg::ROW_LO_ADDR |=> rdata == $past(array_r[0]))
    else $error("row low word read wrong");

  AST_STATUS_READ: assert property (@(posedge clk) disable iff (reset)
    rd && addr == cfg_row_pkg::STATUS_ADDR |=> rdata[1:0] == $past(state_r))
    else $error("status read wrong");

  AST_IDLE_READ: assert property (@(posedge clk) disable iff (reset)
    !rd |=> rdata == 32'h0000_0000)
    else $error("read data stood longer than one cycle");

  AST_PROG_WRITE: assert property (@(posedge clk)
    init_r && wr && addr == cfg_row_pkg::PROG_LO_ADDR |=> array_r[0] == $past(wdata))
    else $error("row low word write lost");

endmodule

// ===== bench/periph_cfg_sink.sv
// Peripheral side model that captures settings as the peripherals leave reset
`timescale 1ns/100ps
module periph_cfg_sink (
  input  wire logic                       clk,
  input  wire logic                       periph_reset,
  input  wire cfg_row_pkg::nvm_cfg_t      nvm_cfg,
  input  wire cfg_row_pkg::brownout_cfg_t brownout_cfg,
  input  wire cfg_row_pkg::watchdog_cfg_t watchdog_cfg,
  output logic [46:0]                     seen,
  output logic                            taken
);
  logic held_r = 1'b1;
  // Settings are taken on the first cycle out of reset
  always_ff @(posedge clk) begin
    held_r <= periph_reset;
    if (periph_reset) begin
      taken <= 1'b0;
    end else if (held_r) begin
      seen <= {nvm_cfg, brownout_cfg, watchdog_cfg};
      taken <= 1'b1;
    end
  end
endmodule

// ===== bench/testbench.sv
// Self-checking bench for the power-on configuration row loader
`timescale 1ns/100ps
module testbench;
  logic                       clk, reset, wr, rd, periph_reset, taken;
  logic [31:0]                addr, wdata, rdata, rv;
  cfg_row_pkg::nvm_cfg_t      nvm_cfg;
  cfg_row_pkg::brownout_cfg_t brownout_cfg;
  cfg_row_pkg::watchdog_cfg_t watchdog_cfg;
  logic [46:0]                seen;
  logic [63:0]                mrow, nrow;
  int                         num_errors, compares, seed, i;
  // Reserved bits that software leaves at their factory state
  localparam logic [63:0] RSV = 64'h0000_fc00_03fe_0088;

  power_on_config_row_loader dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .nvm_cfg(nvm_cfg), .brownout_cfg(brownout_cfg),
    .watchdog_cfg(watchdog_cfg), .periph_reset(periph_reset));
  periph_cfg_sink sink (.clk(clk), .periph_reset(periph_reset), .nvm_cfg(nvm_cfg),
    .brownout_cfg(brownout_cfg), .watchdog_cfg(watchdog_cfg), .seen(seen), .taken(taken));

  function automatic logic [46:0] fields(input logic [63:0] r);
    return {r[2:0], r[6:4], r[63:48], r[13:8], r[14], r[16:15], r[41],
            r[26], r[27], r[31:28], r[35:32], r[39:36], r[40]};
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("Checks %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic do_reset;
    int n;
    @(posedge clk);
    reset <= 1'b1;
    repeat (10) @(posedge clk);
    #1 chk(fields(cfg_row_pkg::ROW_FACTORY), {nvm_cfg, brownout_cfg, watchdog_cfg}, "rst");
    chk(periph_reset, 1, "held");
    @(posedge clk);
    reset <= 1'b0;
    n = 0;
    while (periph_reset !== 1'b0 && n < 8) begin
      @(posedge clk);
      #1 n++;
    end
    if (n == 8) begin
      num_errors++;
      wrap_up();
    end
    chk(n, 3, "release");
    n = 0;
    while (taken !== 1'b1 && n < 4) begin
      @(posedge clk);
      #1 n++;
    end
    if (n == 4) begin
      num_errors++;
      wrap_up();
    end
    chk(seen, fields(mrow), "seen");
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    reset = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = '0;
    wdata = '0;
    num_errors = 0;
    compares = 0;
    seed = 12993;
    mrow = cfg_row_pkg::ROW_FACTORY;
    do_reset();
    chk({nvm_cfg, brownout_cfg, watchdog_cfg}, fields(mrow), "fac");
    bus_rd(cfg_row_pkg::STATUS_ADDR, rv);
    chk(rv[1:0], 2'h2, "status");
    @(posedge clk);
    #1 chk(rdata, 0, "rdata idle");
    bus_rd(32'h0000_0010, rv);
    chk(rv, 0, "unmapped");
    for (i = 0; i < 4; i++) begin
      nrow = (i == 0) ? '1 : (i == 1) ? '0 : {$random(seed), $random(seed)};
      nrow = (nrow & ~RSV) | (cfg_row_pkg::ROW_FACTORY & RSV);
      bus_wr(cfg_row_pkg::PROG_LO_ADDR, nrow[31:0]);
      bus_wr(cfg_row_pkg::PROG_HI_ADDR, nrow[63:32]);
      bus_rd(cfg_row_pkg::ROW_HI_ADDR, rv);
      chk(rv, nrow[63:32], "row hi");
      bus_rd(cfg_row_pkg::PROG_LO_ADDR, rv);
      chk(rv, nrow[31:0], "prog lo");
      chk({nvm_cfg, brownout_cfg, watchdog_cfg}, fields(mrow), "stale");
      chk(periph_reset, 0, "run");
      mrow = nrow;
      do_reset();
      chk({nvm_cfg, brownout_cfg, watchdog_cfg}, fields(mrow), "cfg");
      chk({nvm_cfg, brownout_cfg, watchdog_cfg}, fields(mrow), "cfg2");
      bus_rd(cfg_row_pkg::ROW_LO_ADDR, rv);
      chk(rv, mrow[31:0], "row lo");
    end
    wrap_up();
  end
endmodule
